// ===== logic/down_timer_consts.svh
/*
  Register indices, field positions, reset values and divider limits of the
  two-channel presettable down timer.
  Assumes inclusion by bare name from the design modules.
*/
`ifndef DOWN_TIMER_CONSTS_SVH
`define DOWN_TIMER_CONSTS_SVH

// register index = idx, byte address = 4 * idx; idx[9:7] picks the region
`define REGION_GLOBAL    3'h2
`define OFS_CLK          7'h00
`define OFS_TR           7'h02
`define OFS_TC           7'h04
`define OFS_CTL          7'h06
`define OFS_INT          7'h08
`define OFS_IRQ_STAT     7'h10
`define OFS_IRQ_CLR      7'h12
`define OFS_IRQ_EN       7'h14

`define CTL_RUN_BIT      0
`define CTL_PRESET_BIT   1
`define CTL_MODE_BIT     4
`define INT_FLAG_BIT     0
`define INT_EN_BIT       8
`define DIV_SEL_LSB      0
`define DIV_SEL_MSB      3

`define DIV_SEL_RESET    4'h0
`define DIV_SEL_MAX      4'he
`define RELOAD_RESET     16'h0000
`define COUNT_RESET      16'hffff
`define PRESC_WIDTH      14

`endif

// ===== logic/down_timer_pkg.sv
/*
  Types shared by the down timer channel and its register front end.
  Assumes down_timer_consts.svh is on the include path.
*/
package down_timer_pkg;

  typedef logic [15:0] word16_t;

  typedef enum logic {
    MODE_REPEAT,
    MODE_ONE_SHOT
  } count_mode_t;

endpackage : down_timer_pkg

// ===== logic/timer_channel.sv
/*
  One timer channel: power-of-two prescaler, 16-bit down counter, run state
  and underflow pulse.
  Assumes register strobes arrive as one-cycle pulses on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "down_timer_consts.svh"

module timer_channel
  import down_timer_pkg::*;
#(
  parameter int PRESC_W = `PRESC_WIDTH
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  div_sel,
  input  wire count_mode_t mode,
  input  wire word16_t     reload,
  input  wire logic        preset_stb,
  input  wire logic        run_wr,
  input  wire logic        run_val,
  output word16_t          count_q,
  output logic             run_q,
  output logic             underflow_q
);

  logic [PRESC_W-1:0] presc_q;
  logic [PRESC_W-1:0] mask;
  logic               tick;
  logic               uf_event;

  // low div_sel bits of the prescaler all set marks one count-clock tick
  assign mask = ~({PRESC_W{1'b1}} << div_sel);                   // [RULE1]
  assign tick = run_q && (div_sel <= `DIV_SEL_MAX)
                && ((presc_q & mask) == mask);                   // [RULE1]
  assign uf_event = tick && (count_q == 16'h0000) && !preset_stb; // [RULE18]

  // prescaler restarts at zero on every start for a whole first period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= '0;
    end else if (!run_q) begin
      presc_q <= '0;                                              // [RULE6]
    end else begin
      presc_q <= presc_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= `COUNT_RESET;                                    // [RULE15]
    end else if (preset_stb) begin
      count_q <= reload;                                          // [RULE7]
    end else if (tick) begin
      if (count_q == 16'h0000) begin
        count_q <= reload;                 // [RULE18] [RULE4] [RULE3]
      end else begin
        count_q <= count_q - 16'h0001;                            // [RULE6]
      end
    end
  end

  // a software write in the same cycle beats the one-shot stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else if (run_wr) begin
      run_q <= run_val;                                   // [RULE8] [RULE9]
    end else if (uf_event && mode == MODE_ONE_SHOT) begin
      run_q <= 1'b0;                                              // [RULE5]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      underflow_q <= 1'b0;
    end else begin
      underflow_q <= uf_event;                                    // [RULE10]
    end
  end

endmodule : timer_channel

`default_nettype wire

// ===== logic/presettable_down_timer.sv
/*
  Two-channel presettable 16-bit down timer with an APB register front end,
  per-channel and summary interrupt requests and serial clock outputs.
  Assumes one clock pclk, an APB master on the same clock and a consumer of
  the one-cycle underflow pulses.
*/
// The APB interface to the registers and the register offsets were chosen for this implementation.
// Overview of operation
// [RULE1] count clock is pclk over 2**select, codes 0..e; f gives no ticks
// [RULE2] software halts the counter before changing the divide select
// [RULE3] each channel has a 16-bit down counter and 16-bit reload value
// [RULE4] repeat mode reloads on underflow and keeps counting
// [RULE5] one-shot mode reloads on underflow, then stops by itself
// [RULE6] start to underflow, and between underflows, is reload+1 ticks
// [RULE7] writing the timer reset strobe presets the counter with reload
// [RULE8] writing run 1 starts counting from the counter's present value
// [RULE9] writing run 0 stops and holds the counter value
// [RULE10] each underflow pulses, reloads and requests an interrupt together; the counter reloads one pclk before underflow_pulse and the flag rise
// [RULE11] the underflow pulse is also driven out as a serial clock
// [RULE12] software configures everything, presets, then sets run
// [RULE13] software presets before run to restart from the reload value
// [RULE14] two identical channels differing only in register addresses
// [RULE15] counter reads back, is not writable, resets to ffff
// [RULE16] underflow sets a flag; request forwarded only when enabled
// [RULE17] writing 1 clears the flag; software clears it before enabling
// [RULE18] a tick at zero is the underflow and loads reload instead of wrap
`timescale 1ns/1ps
`default_nettype none
`include "down_timer_consts.svh"

module presettable_down_timer
  import down_timer_pkg::*;
#(
  parameter int NUM_CH  = 2,
  parameter int ADDR_W  = 12,
  parameter int PRESC_W = `PRESC_WIDTH
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  output logic [NUM_CH-1:0]      channel_irq,
  output logic [NUM_CH-1:0]      underflow_pulse,
  output logic [NUM_CH-1:0]      serial_clk
);

  // bus decode and response
  logic [ADDR_W-3:0] idx;
  logic [2:0]        region;
  logic [6:0]        ofs;
  logic              setup;
  logic              wr_en;
  logic              mapped;
  logic [15:0]       lane_mask;
  logic [15:0]       wdata16;
  logic [31:0]       rd_data;

  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;

  assign idx       = paddr[ADDR_W-1:2];
  assign region    = idx[9:7];
  assign ofs       = idx[6:0];
  assign setup     = psel && !penable;
  assign wr_en     = psel && penable && pready_q && pwrite && mapped;
  assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wdata16   = pwdata[15:0];

  // channel state
  logic [3:0]          div_sel_q   [NUM_CH];
  word16_t             reload_q    [NUM_CH];
  count_mode_t         mode_q      [NUM_CH];
  word16_t             count_w     [NUM_CH];
  logic [NUM_CH-1:0]   run_w;
  logic [NUM_CH-1:0]   uf_w;
  logic [NUM_CH-1:0]   ch_wr;
  logic [NUM_CH-1:0]   preset_stb;
  logic [NUM_CH-1:0]   run_wr;
  logic [NUM_CH-1:0]   flag_q;
  logic [NUM_CH-1:0]   flag_d;
  logic [NUM_CH-1:0]   flag_clr;
  logic [NUM_CH-1:0]   irq_en_q;
  logic [NUM_CH-1:0]   irq_en_d;
  logic                glb_wr;
  logic [NUM_CH-1:0]   channel_irq_q;
  logic [NUM_CH-1:0]   underflow_q;
  logic [NUM_CH-1:0]   serial_clk_q;
  logic                irq_q;

  assign glb_wr = wr_en && (region == `REGION_GLOBAL);

  // unaligned byte addresses and unknown indices answer with an error
  always_comb begin
    mapped = 1'b0;
    if (paddr[1:0] == 2'b00) begin
      if (region < 3'(NUM_CH)) begin
        unique case (ofs)
          `OFS_CLK, `OFS_TR, `OFS_TC, `OFS_CTL, `OFS_INT: begin
            mapped = 1'b1;
          end
          default: begin
            mapped = 1'b0;
          end
        endcase
      end else if (region == `REGION_GLOBAL) begin
        unique case (ofs)
          `OFS_IRQ_STAT, `OFS_IRQ_CLR, `OFS_IRQ_EN: begin
            mapped = 1'b1;
          end
          default: begin
            mapped = 1'b0;
          end
        endcase
      end
    end
  end

  // read mux; reserved bits and write-only fields read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (mapped && region < 3'(NUM_CH)) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (region == 3'(c)) begin
          unique case (ofs)
            `OFS_CLK: begin
              rd_data[`DIV_SEL_MSB:`DIV_SEL_LSB] = div_sel_q[c];
            end
            `OFS_TR: begin
              rd_data[15:0] = reload_q[c];
            end
            `OFS_TC: begin
              rd_data[15:0] = count_w[c];                         // [RULE15]
            end
            `OFS_CTL: begin
              rd_data[`CTL_MODE_BIT] = (mode_q[c] == MODE_ONE_SHOT);
              rd_data[`CTL_RUN_BIT]  = run_w[c];
            end
            `OFS_INT: begin
              rd_data[`INT_EN_BIT]   = irq_en_q[c];
              rd_data[`INT_FLAG_BIT] = flag_q[c];
            end
            default: begin
              rd_data = 32'h0000_0000;
            end
          endcase
        end
      end
    end else if (mapped && region == `REGION_GLOBAL) begin
      if (ofs == `OFS_IRQ_STAT) begin
        rd_data[NUM_CH-1:0] = flag_q;
      end else if (ofs == `OFS_IRQ_EN) begin
        rd_data[NUM_CH-1:0] = irq_en_q;
      end
    end
  end

  // zero-wait slave: data and pready are prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= setup && !mapped;
    end
  end

  // per channel registers and timer
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch                // [RULE14]
    logic ctl_wr;
    logic int_wr;

    assign ch_wr[g]      = wr_en && (region == 3'(g));
    assign ctl_wr        = ch_wr[g] && (ofs == `OFS_CTL) && pstrb[0];
    assign int_wr        = ch_wr[g] && (ofs == `OFS_INT);
    assign preset_stb[g] = ctl_wr && pwdata[`CTL_PRESET_BIT];     // [RULE7]
    assign run_wr[g]     = ctl_wr;                        // [RULE8] [RULE9]

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        div_sel_q[g] <= `DIV_SEL_RESET;                           // [RULE1]
      end else if (ch_wr[g] && ofs == `OFS_CLK && pstrb[0]) begin
        div_sel_q[g] <= wdata16[`DIV_SEL_MSB:`DIV_SEL_LSB];       // [RULE1]
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        reload_q[g] <= `RELOAD_RESET;
      end else if (ch_wr[g] && ofs == `OFS_TR) begin
        reload_q[g] <= (reload_q[g] & ~lane_mask)
                       | (wdata16 & lane_mask);                   // [RULE3]
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mode_q[g] <= MODE_REPEAT;                                 // [RULE4]
      end else if (ctl_wr) begin
        mode_q[g] <= pwdata[`CTL_MODE_BIT] ? MODE_ONE_SHOT
                                           : MODE_REPEAT; // [RULE4] [RULE5]
      end
    end

    // clear by a 1 in the flag bit or in the summary clear register
    assign flag_clr[g] = (int_wr && pstrb[0] && pwdata[`INT_FLAG_BIT])
                         || (glb_wr && ofs == `OFS_IRQ_CLR && pstrb[0]
                             && pwdata[g]);                       // [RULE17]
    // a new underflow beats a clear in the same cycle
    assign flag_d[g] = uf_w[g] || (flag_q[g] && !flag_clr[g]);    // [RULE16]

    always_comb begin
      irq_en_d[g] = irq_en_q[g];
      if (int_wr && pstrb[1]) begin
        irq_en_d[g] = pwdata[`INT_EN_BIT];
      end else if (glb_wr && ofs == `OFS_IRQ_EN && pstrb[0]) begin
        irq_en_d[g] = pwdata[g];
      end
    end

    timer_channel #(
      .PRESC_W     (PRESC_W)
    ) u_channel (
      .pclk        (pclk),
      .presetn     (presetn),
      .div_sel     (div_sel_q[g]),
      .mode        (mode_q[g]),
      .reload      (reload_q[g]),
      .preset_stb  (preset_stb[g]),
      .run_wr      (run_wr[g]),
      .run_val     (pwdata[`CTL_RUN_BIT]),
      .count_q     (count_w[g]),
      .run_q       (run_w[g]),
      .underflow_q (uf_w[g])
    );
  end

  // interrupt flags and requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;                                           // [RULE16]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= '0;                                             // [RULE16]
    end else begin
      irq_en_q <= irq_en_d;
    end
  end

  // requests follow the next flag value so they rise with the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_irq_q <= '0;
    end else begin
      channel_irq_q <= flag_d & irq_en_d;                 // [RULE10] [RULE16]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flag_d & irq_en_d);                              // [RULE16]
    end
  end

  // pulse outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      underflow_q <= '0;
    end else begin
      underflow_q <= uf_w;                                        // [RULE10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_clk_q <= '0;
    end else begin
      serial_clk_q <= uf_w;                                       // [RULE11]
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign irq             = irq_q;
  assign channel_irq     = channel_irq_q;
  assign underflow_pulse = underflow_q;
  assign serial_clk      = serial_clk_q;

endmodule : presettable_down_timer

`default_nettype wire

// ===== test/timer_properties.sv
/*
  Port checker for the two-channel down timer: bus timing, serial clock
  and interrupt relations.
  Assumes binding onto presettable_down_timer, one clock pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module timer_checker #(
  parameter int NUM_CH = 2,
  parameter int ADDR_W = 12
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              irq,
  input wire logic [NUM_CH-1:0] channel_irq,
  input wire logic [NUM_CH-1:0] underflow_pulse,
  input wire logic [NUM_CH-1:0] serial_clk
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_clr0;
    psel && penable && pready && pwrite && pstrb[0] && pwdata[0] &&
      paddr == ADDR_W'(12'h020);
  endsequence

  property p_ready;
    s_setup |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_ready_only;
    pready |-> $past(psel) && !$past(penable);
  endproperty
  a_ready_only: assert property (p_ready_only) else $error("stray ready");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_unaligned;
    s_setup ##0 (paddr[1:0] != 2'h0) |=> pslverr && pready;
  endproperty
  a_unaligned: assert property (p_unaligned) else $error("no error");
  property p_rdata_hi;
    pready |-> prdata[31:16] == 16'h0000;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits");
  property p_serial;
    serial_clk == underflow_pulse;
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial clock differs");
  property p_irq_sum;
    irq == |channel_irq;
  endproperty
  a_irq_sum: assert property (p_irq_sum)
    else $error("summary irq wrong");
  property p_clear;
    s_clr0 |-> ##2 (!channel_irq[0] || underflow_pulse[0] ||
      $past(underflow_pulse[0]));
  endproperty
  a_clear: assert property (p_clear)
    else $error("flag clear ignored");
endmodule : timer_checker

bind presettable_down_timer timer_checker #(
  .NUM_CH(NUM_CH),
  .ADDR_W(ADDR_W)
) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .channel_irq(channel_irq), .underflow_pulse(underflow_pulse),
  .serial_clk(serial_clk)
);

`default_nettype wire

// ===== test/irq_sink.sv
/*
  Far-side model: interrupt controller and serial clock consumers.
  Assumes one-cycle serial clock pulses on pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module irq_sink (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        irq,
  input wire logic [1:0]  serial_clk,
  output logic [1:0][15:0] clk_cnt,
  output logic [15:0]     irq_cnt
);
  logic irq_q;

  // counts transfer clocks per channel and interrupt requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_cnt <= '0;
      irq_cnt <= '0;
      irq_q   <= 1'b0;
    end else begin
      irq_q <= irq;
      if (irq && !irq_q) irq_cnt <= irq_cnt + 16'h0001;
      for (int c = 0; c < 2; c++) begin
        if (serial_clk[c]) clk_cnt[c] <= clk_cnt[c] + 16'h0001;
      end
    end
  end
endmodule : irq_sink

`default_nettype wire

// ===== test/presettable_down_timer_tb_top.sv
/*
  Self-checking bench for the two-channel down timer over APB.
  Assumes the design, its checker bind and irq_sink are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module presettable_down_timer_tb_top;
  import down_timer_pkg::*;
  localparam logic [11:0] CLK = 12'h000, TR = 12'h008, TC = 12'h010;
  localparam logic [11:0] CTL = 12'h018, INT = 12'h020, STAT = 12'h440;
  localparam logic [11:0] CLR = 12'h448, EN = 12'h450;
  logic        pclk, presetn, psel, penable, pwrite, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        pready, pslverr;
  logic [1:0]  channel_irq, underflow_pulse, serial_clk;
  logic [1:0][15:0] clk_cnt;
  logic [15:0] irq_cnt;
  int          failures, n_checks;

  presettable_down_timer uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .channel_irq(channel_irq), .underflow_pulse(underflow_pulse),
    .serial_clk(serial_clk)
  );
  irq_sink sink (
    .pclk(pclk), .presetn(presetn), .irq(irq), .serial_clk(serial_clk),
    .clk_cnt(clk_cnt), .irq_cnt(irq_cnt)
  );

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= 4'h3;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdc(input string w, input logic [11:0] a,
                     input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    check(w, rd, exp);
  endtask : rdc

  task automatic wait_pulse(input int c, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (underflow_pulse[c] !== 1'b1);
  endtask : wait_pulse

  task automatic start(input logic [11:0] b, input logic [3:0] dv,
                       input logic [15:0] r, input logic md);
    wr(b + CLK, {28'h0, dv});
    wr(b + TR, {16'h0, r});
    wr(b + CTL, {27'h0, md, 4'h2});
    wr(b + CTL, {27'h0, md, 4'h1});
  endtask : start

  task automatic t_resets();
    logic [31:0] rd;
    logic        err;
    for (int c = 0; c < 2; c++) begin
      rdc("div", c * 12'h200 + CLK, 32'h0);
      rdc("reload", c * 12'h200 + TR, 32'h0);
      rdc("count", c * 12'h200 + TC, 32'h0000ffff);
      rdc("ctl", c * 12'h200 + CTL, 32'h0);
      rdc("int", c * 12'h200 + INT, 32'h0);
    end
    wr(TC, 32'h00001234);
    rdc("count ro", TC, 32'h0000ffff);
    apb(1'b0, 12'h0fc, 32'h0, rd, err);
    check("unmapped", {31'h0, err}, 32'h1);
    apb(1'b1, 12'h202, 32'h0000000f, rd, err);
    check("unaligned", {31'h0, err}, 32'h1);
    rdc("unaligned ignored", 12'h200 + CLK, 32'h0);
  endtask : t_resets

  task automatic t_period(input int c, input int dv, input int r);
    int n;
    start(c * 12'h200, dv[3:0], r[15:0], 1'b0);
    wait_pulse(c, n);
    check("first", n, ((r + 1) << dv) + 2);
    wait_pulse(c, n);
    check("period", n, (r + 1) << dv);
    wr(c * 12'h200 + CTL, 32'h0);
  endtask : t_period

  task automatic t_one_shot();
    logic [15:0] c0;
    int          n;
    wr(INT, 32'h1);
    c0 = clk_cnt[0];
    start(CLK, 4'h0, 16'h0003, 1'b1);
    wait_pulse(0, n);
    repeat (30) @(posedge pclk);
    check("one pulse", clk_cnt[0] - c0, 32'h1);
    rdc("stopped", CTL, 32'h10);
    rdc("reloaded", TC, 32'h3);
  endtask : t_one_shot

  task automatic t_irq();
    rdc("flag", INT, 32'h1);
    check("masked", channel_irq, 2'b00);
    rdc("stat", STAT, 32'h3);
    wr(INT, 32'h100);
    repeat (2) @(posedge pclk);
    check("raised", {channel_irq, irq}, 3'b011);
    rdc("en alias", EN, 32'h1);
    wr(CLR, 32'h2);
    rdc("stat clr", STAT, 32'h1);
    wr(INT, 32'h101);
    repeat (2) @(posedge pclk);
    check("irq low", irq, 1'b0);
    rdc("int", INT, 32'h100);
    check("irq count", irq_cnt, 32'h1);
    wr(EN, 32'h2);
    rdc("en write", 12'h200 + INT, 32'h100);
    rdc("en write ch0", INT, 32'h0);
  endtask : t_irq

  task automatic t_stop();
    logic [31:0] v;
    logic        err;
    int          n;
    start(CLK, 4'h0, 16'h00c8, 1'b0);
    repeat (20) @(posedge pclk);
    wr(CTL, 32'h0);
    apb(1'b0, TC, 32'h0, v, err);
    repeat (20) @(posedge pclk);
    rdc("held", TC, v);
    wr(CTL, 32'h1);
    wait_pulse(0, n);
    check("resume", n, v + 3);
    wr(CTL, 32'h0);
    wr(CTL, 32'h2);
    rdc("preset", TC, 32'h0000_00c8);
    wr(CLK, 32'hf);
    wr(CTL, 32'h1);
    repeat (10) @(posedge pclk);
    rdc("no ticks", TC, 32'h0000_00c8);
    wr(CTL, 32'h0);
  endtask : t_stop

  task automatic conclude();
    if (failures == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    conclude();
  end

  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata, pstrb} = '0;
    failures = 0;
    n_checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_resets();
    t_period(0, 0, 0);
    t_period(0, 3, 5);
    t_period(1, 1, 2);
    t_period(1, 14, 0);
    t_one_shot();
    t_irq();
    t_stop();
    conclude();
  end
endmodule : presettable_down_timer_tb_top

`default_nettype wire
